// File: rtl/pcio_pin.sv
// Logic behind I/O pin 1: protection-clear pulse exchange, level input, output.
// Assumes settings are quasi-static ports; pin is open-collector style, three signals.
`timescale 1ns/1ns
// Function
// - Pin takes exactly one function: protection clear, general input or general output.
// - Invert setting reverses the sense of every pin pulse and level.
// - In protection-clear function, pin activity can clear latched protection.
// - In input function, the pin level is detected and reported internally.
// - In output function, drive constant true, constant false or PWM.
// - True drives low normally, high when inverted.
// - False drives high normally, low when inverted.
// - PWM period and active fraction come from programmable settings.
// - Protection-clear function is bidirectional: receives and sends pulses.
// - Exchanged pulses hold their active low phase at least 30 us.
// - Valid incoming pulse clears latched protection.
// - After protection release, load turning off-to-on emits one pulse.
// - A pulse is a high-to-low edge in default polarity.
module pcio_pin (
  input wire logic ref_clk,
  input wire logic nrst,
  input pcio_pkg::pcio_cfg_s cfg,
  input wire logic protection_latched,
  input wire logic load_on,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic protection_clear,
  output logic input_level
);

  logic sync1;
  logic pin_sync;
  logic rx_active;
  logic rx_seen_idle;
  logic [pcio_pkg::CNT_W-1:0] rx_cnt;
  logic rx_hit;
  logic load_d;
  logic load_rise;
  logic release_armed;
  logic prot_d;
  logic emit_req;
  pcio_pkg::pcio_tx_e tx_state;
  pcio_pkg::pcio_tx_e next_tx_state;
  logic [pcio_pkg::CNT_W-1:0] tx_cnt;
  logic pwm_act;
  logic next_pin_out;
  logic next_pin_oe;
  logic is_clear;

  assign is_clear = (cfg.func == pcio_pkg::PCIO_FUNC_CLEAR);

  // Two-flop synchroniser; only the second stage is used
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= pcio_pkg::PIN_IDLE_LVL;
      pin_sync <= pcio_pkg::PIN_IDLE_LVL;
    end else begin
      sync1 <= pin_in;
      pin_sync <= sync1;
    end
  end

  // Detected level after polarity
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      input_level <= pcio_pkg::PIN_IDLE_LVL;
    end else if (cfg.func == pcio_pkg::PCIO_FUNC_INPUT) begin
      input_level <= pin_sync ^ cfg.invert;
    end
  end

  // Incoming pulse: active level is low, or high when inverted
  assign rx_active = (pin_sync == cfg.invert) && is_clear && (tx_state == pcio_pkg::PCIO_TX_IDLE);
  assign rx_hit = rx_active && rx_seen_idle && (rx_cnt == pcio_pkg::PULSE_CYC - pcio_pkg::CNT_W'(1));

  // A level stuck active from start is no edge, so an idle level must be seen first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_seen_idle <= 1'b0;
    end else if (!is_clear) begin
      rx_seen_idle <= 1'b0;
    end else if (!rx_active && tx_state == pcio_pkg::PCIO_TX_IDLE) begin
      rx_seen_idle <= 1'b1;
    end
  end

  // Low-time counter, saturating; glitches restart it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt <= '0;
    end else if (!rx_active || !rx_seen_idle) begin
      rx_cnt <= '0;
    end else if (rx_cnt != pcio_pkg::PULSE_CYC) begin
      rx_cnt <= rx_cnt + pcio_pkg::CNT_W'(1);
    end
  end

  // One-cycle clear request once the minimum width is met
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      protection_clear <= 1'b0;
    end else begin
      protection_clear <= rx_hit && protection_latched;
    end
  end

  // Release tracking; a fresh release wins over the clear from emission
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prot_d <= 1'b0;
      load_d <= 1'b0;
    end else begin
      prot_d <= protection_latched;
      load_d <= load_on;
    end
  end

  assign load_rise = load_on && !load_d;
  assign emit_req = load_rise && release_armed && !protection_latched && is_clear;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      release_armed <= 1'b0;
    end else if (prot_d && !protection_latched) begin
      release_armed <= 1'b1;
    end else if (protection_latched || (emit_req && tx_state == pcio_pkg::PCIO_TX_IDLE)) begin
      release_armed <= 1'b0;
    end
  end

  // Outgoing pulse sequencer
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      pcio_pkg::PCIO_TX_IDLE: begin
        if (emit_req) begin
          next_tx_state = pcio_pkg::PCIO_TX_DRIVE;
        end
      end
      pcio_pkg::PCIO_TX_DRIVE: begin
        if (!is_clear) begin
          next_tx_state = pcio_pkg::PCIO_TX_IDLE;
        end else if (tx_cnt == pcio_pkg::PULSE_CYC - pcio_pkg::CNT_W'(1)) begin
          next_tx_state = pcio_pkg::PCIO_TX_SETTLE;
        end
      end
      pcio_pkg::PCIO_TX_SETTLE: begin
        if (!is_clear || tx_cnt == pcio_pkg::SETTLE_CYC - pcio_pkg::CNT_W'(1)) begin
          next_tx_state = pcio_pkg::PCIO_TX_IDLE;
        end
      end
      default: begin
        next_tx_state = pcio_pkg::PCIO_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= pcio_pkg::PCIO_TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt <= '0;
    end else if (next_tx_state != tx_state) begin
      tx_cnt <= '0;
    end else if (tx_state != pcio_pkg::PCIO_TX_IDLE) begin
      tx_cnt <= tx_cnt + pcio_pkg::CNT_W'(1);
    end
  end

  pcio_pwm u_pwm (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(cfg.func == pcio_pkg::PCIO_FUNC_OUTPUT && cfg.src == pcio_pkg::PCIO_SRC_PWM),
    .period(cfg.pwm_period),
    .active(cfg.pwm_active),
    .pwm_active(pwm_act)
  );

  // Pin drive selection; illegal function codes release the pin
  always_comb begin
    next_pin_out = pcio_pkg::PIN_IDLE_LVL;
    next_pin_oe = 1'b0;
    unique case (cfg.func)
      pcio_pkg::PCIO_FUNC_CLEAR: begin
        next_pin_oe = (next_tx_state == pcio_pkg::PCIO_TX_DRIVE);
        next_pin_out = pcio_pkg::pin_level(1'b1, cfg.invert);
      end
      pcio_pkg::PCIO_FUNC_INPUT: begin
        next_pin_oe = 1'b0;
      end
      pcio_pkg::PCIO_FUNC_OUTPUT: begin
        next_pin_oe = 1'b1;
        unique case (cfg.src)
          pcio_pkg::PCIO_SRC_TRUE: next_pin_out = pcio_pkg::pin_level(1'b1, cfg.invert);
          pcio_pkg::PCIO_SRC_FALSE: next_pin_out = pcio_pkg::pin_level(1'b0, cfg.invert);
          pcio_pkg::PCIO_SRC_PWM: next_pin_out = pcio_pkg::pin_level(pwm_act, cfg.invert);
          default: next_pin_out = pcio_pkg::pin_level(1'b0, cfg.invert);
        endcase
      end
      default: begin
        next_pin_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= pcio_pkg::PIN_IDLE_LVL;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // Helper: length of the current driven pulse in clear function
  logic [pcio_pkg::CNT_W-1:0] drv_len;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      drv_len <= '0;
    end else if (pin_oe && is_clear) begin
      drv_len <= drv_len + pcio_pkg::CNT_W'(1);
    end else begin
      drv_len <= '0;
    end
  end

  property p_input_released;
    @(posedge ref_clk) disable iff (!nrst)
    (cfg.func == pcio_pkg::PCIO_FUNC_INPUT) ##1 (cfg.func == pcio_pkg::PCIO_FUNC_INPUT) |-> !pin_oe;
  endproperty
  a_input_released: assert property (p_input_released) else $error("pin driven in input function");

  property p_true_level;
    @(posedge ref_clk) disable iff (!nrst)
    (cfg.func == pcio_pkg::PCIO_FUNC_OUTPUT && cfg.src == pcio_pkg::PCIO_SRC_TRUE) ##1
    $stable(cfg) |-> pin_oe && (pin_out == cfg.invert);
  endproperty
  a_true_level: assert property (p_true_level) else $error("true source wrong level");

  property p_false_level;
    @(posedge ref_clk) disable iff (!nrst)
    (cfg.func == pcio_pkg::PCIO_FUNC_OUTPUT && cfg.src == pcio_pkg::PCIO_SRC_FALSE) ##1
    $stable(cfg) |-> pin_oe && (pin_out == !cfg.invert);
  endproperty
  a_false_level: assert property (p_false_level) else $error("false source wrong level");

  property p_pwm_follow;
    @(posedge ref_clk) disable iff (!nrst)
    (cfg.func == pcio_pkg::PCIO_FUNC_OUTPUT && cfg.src == pcio_pkg::PCIO_SRC_PWM) ##1
    $stable(cfg) |-> pin_out == ($past(pwm_act) ~^ cfg.invert);
  endproperty
  a_pwm_follow: assert property (p_pwm_follow) else $error("pin not following pwm");

  property p_drive_width;
    @(posedge ref_clk) disable iff (!nrst)
    $fell(pin_oe) && is_clear && $past(is_clear) |-> drv_len == pcio_pkg::PULSE_CYC;
  endproperty
  a_drive_width: assert property (p_drive_width) else $error("emitted pulse width wrong");

  property p_clear_cause;
    @(posedge ref_clk) disable iff (!nrst)
    protection_clear |-> $past(protection_latched) && $past(rx_cnt) == pcio_pkg::PULSE_CYC - pcio_pkg::CNT_W'(1);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("clear without valid pulse");

  property p_clear_single;
    @(posedge ref_clk) disable iff (!nrst)
    protection_clear |=> !protection_clear;
  endproperty
  a_clear_single: assert property (p_clear_single) else $error("clear longer than one cycle");

  property p_emit_start;
    @(posedge ref_clk) disable iff (!nrst)
    emit_req && tx_state == pcio_pkg::PCIO_TX_IDLE |=> pin_oe && pin_out == cfg.invert;
  endproperty
  a_emit_start: assert property (p_emit_start) else $error("no pulse after turn on");

  property p_clear_drive_level;
    @(posedge ref_clk) disable iff (!nrst)
    pin_oe && is_clear && $stable(cfg.invert) |-> pin_out == cfg.invert;
  endproperty
  a_clear_drive_level: assert property (p_clear_drive_level) else $error("pulse at idle level");

  property p_input_report;
    @(posedge ref_clk) disable iff (!nrst)
    cfg.func == pcio_pkg::PCIO_FUNC_INPUT |=> input_level == ($past(pin_sync) ^ $past(cfg.invert));
  endproperty
  a_input_report: assert property (p_input_report) else $error("input level not reported");

  c_clear: cover property (@(posedge ref_clk) disable iff (!nrst) protection_clear);
  c_emit: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(pin_oe) && is_clear);
  c_pwm: cover property (@(posedge ref_clk) disable iff (!nrst)
    cfg.src == pcio_pkg::PCIO_SRC_PWM && pin_oe && $rose(pin_out));

endmodule : pcio_pin

// File: rtl/pcio_pkg.sv
// Package for the protection-clear I/O pin: modes, settings carrier, timing.
// Assumes a single 100 MHz clock and no register bus.
package pcio_pkg;

  // Clock and pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_LOW_NS = 30000;
  // Least time, rounded up to whole cycles
  localparam int PULSE_CYC_INT = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(PULSE_CYC_INT);
  // Quiet time after our own pulse so its echo is not taken as input
  localparam logic [CNT_W-1:0] SETTLE_CYC = 12'h008;

  // PWM setting widths and reset values
  localparam int PWM_W = 24;
  localparam logic [PWM_W-1:0] PWM_PERIOD_RST = 24'h000000;
  localparam logic [PWM_W-1:0] PWM_ACTIVE_RST = 24'h000000;

  // Reset levels
  localparam logic PIN_IDLE_LVL = 1'b1;
  localparam logic [1:0] SYNC_RST = 2'h3;

  typedef enum logic [1:0] {
    PCIO_FUNC_CLEAR = 2'h0,
    PCIO_FUNC_INPUT = 2'h1,
    PCIO_FUNC_OUTPUT = 2'h3
  } pcio_func_e;

  typedef enum logic [1:0] {
    PCIO_SRC_TRUE = 2'h0,
    PCIO_SRC_FALSE = 2'h1,
    PCIO_SRC_PWM = 2'h3
  } pcio_src_e;

  typedef enum logic [1:0] {
    PCIO_TX_IDLE = 2'h0,
    PCIO_TX_DRIVE = 2'h1,
    PCIO_TX_SETTLE = 2'h3
  } pcio_tx_e;

  typedef struct packed {
    logic [1:0] func;
    logic invert;
    logic [1:0] src;
    logic [PWM_W-1:0] pwm_period;
    logic [PWM_W-1:0] pwm_active;
  } pcio_cfg_s;

  // Pin level for a logical value: true is low unless inverted
  function automatic logic pin_level(input logic value, input logic invert);
    pin_level = ~value ^ invert;
  endfunction : pin_level

endpackage : pcio_pkg

// File: rtl/pcio_pwm.sv
// PWM generator: active for pwm_active cycles of every pwm_period cycles.
// Assumes settings are static while enabled; a period of zero holds inactive.
`timescale 1ns/1ns
module pcio_pwm (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [pcio_pkg::PWM_W-1:0] period,
  input wire logic [pcio_pkg::PWM_W-1:0] active,
  output logic pwm_active
);

  logic [pcio_pkg::PWM_W-1:0] count;
  logic wrap;

  assign wrap = (count >= period - pcio_pkg::PWM_W'(1));

  // Free-running phase counter; a shrunk period wraps at once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= pcio_pkg::PWM_PERIOD_RST;
    end else if (!enable || period == pcio_pkg::PWM_PERIOD_RST || wrap) begin
      count <= pcio_pkg::PWM_PERIOD_RST;
    end else begin
      count <= count + pcio_pkg::PWM_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_active <= 1'b0;
    end else begin
      pwm_active <= enable && (period != pcio_pkg::PWM_PERIOD_RST) && (count < active);
    end
  end

endmodule : pcio_pwm

// File: tb/pcio_ext.sv
// External instrument on pin 1: drives active-level pulses or levels, measures pulses.
// Assumes an open-collector wire with a pull-up, resolved in the testbench.
`timescale 1ns/1ns
module pcio_ext (
  input wire logic ref_clk,
  input wire logic pin,
  input wire logic invert,
  output logic drv,
  output logic lvl
);
  int falls;
  int low_cnt;
  int last_low;
  logic prev_act;
  wire logic act = pin ^ ~invert;

  initial begin
    drv = 1'b0;
    lvl = 1'b1;
    falls = 0;
    low_cnt = 0;
    last_low = 0;
    prev_act = 1'b0;
  end

  // Falling edge in default sense is the pulse event; low time counted per cycle
  always @(posedge ref_clk) begin
    if (act === 1'b1 && prev_act === 1'b0) falls++;
    if (act === 1'b1) low_cnt++;
    else if (low_cnt != 0) begin
      last_low = low_cnt;
      low_cnt = 0;
    end
    prev_act = act;
  end

  task automatic clear_stats();
    falls = 0;
    last_low = 0;
  endtask : clear_stats

  // Idle, then active for n cycles, then idle held: the instrument drives every level itself, also when inverted
  task automatic pulse(input int n);
    @(posedge ref_clk);
    #1;
    drv = 1'b1;
    lvl = ~invert;
    repeat (4) @(posedge ref_clk);
    #1;
    lvl = invert;
    repeat (n) @(posedge ref_clk);
    #1;
    lvl = ~invert;
  endtask : pulse

  task automatic release_pin();
    @(posedge ref_clk);
    #1;
    drv = 1'b0;
    lvl = 1'b1;
  endtask : release_pin

  task automatic level(input logic l);
    @(posedge ref_clk);
    #1;
    drv = 1'b1;
    lvl = l;
  endtask : level
endmodule : pcio_ext

// File: tb/testbench.sv
// Self-checking bench for the pin 1 logic with an external instrument model.
// Assumes the pin is open-collector with a pull-up; no register bus.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic ref_clk;
  logic nrst;
  pcio_pkg::pcio_cfg_s cfg;
  logic protection_latched;
  logic load_on;
  logic pin_out;
  logic pin_oe;
  logic protection_clear;
  logic input_level;
  logic ext_drv;
  logic ext_lvl;
  int num_errors;
  int samples_checked;
  int clr_cnt;
  int n;
  // Pull-up keeps a released wire high
  wire logic pin = pin_oe ? pin_out : (ext_drv ? ext_lvl : 1'b1);

  pcio_pin i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .protection_latched(protection_latched),
    .load_on(load_on), .pin_in(pin), .pin_out(pin_out), .pin_oe(pin_oe),
    .protection_clear(protection_clear), .input_level(input_level)
  );
  pcio_ext i_ext (.ref_clk(ref_clk), .pin(pin), .invert(cfg.invert), .drv(ext_drv), .lvl(ext_lvl));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (protection_clear === 1'b1) clr_cnt++;

  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic t_output();
    for (int i = 0; i < 4; i++) begin
      cfg.func = pcio_pkg::PCIO_FUNC_OUTPUT;
      cfg.invert = i[0];
      cfg.src = i[1] ? pcio_pkg::PCIO_SRC_FALSE : pcio_pkg::PCIO_SRC_TRUE;
      cyc(4);
      `CHK(pin_oe, 1'b1)
      `CHK(pin_out, i[0] ^ i[1])
    end
    // Spare source code acts as false, spare function code releases the pin
    cfg.invert = 1'b0;
    cfg.src = 2'h2;
    cyc(4);
    `CHK(pin_out, 1'b1)
    cfg.func = 2'h2;
    cyc(4);
    `CHK(pin_oe, 1'b0)
    cfg.func = pcio_pkg::PCIO_FUNC_OUTPUT;
  endtask : t_output

  task automatic t_pwm();
    cfg.invert = 1'b0;
    cfg.pwm_period = 24'h00000a;
    cfg.pwm_active = 24'h000003;
    cfg.src = pcio_pkg::PCIO_SRC_PWM;
    cyc(20);
    n = 0;
    repeat (100) begin
      if (pin_out === 1'b0) n++;
      cyc(1);
    end
    `CHK(n, 30)
  endtask : t_pwm

  task automatic t_input();
    cfg.func = pcio_pkg::PCIO_FUNC_INPUT;
    for (int i = 0; i < 4; i++) begin
      cfg.invert = i[0];
      i_ext.level(i[1]);
      cyc(6);
      `CHK(pin_oe, 1'b0)
      `CHK(input_level, i[1] ^ i[0])
    end
    cfg.invert = 1'b0;
    i_ext.release_pin();
  endtask : t_input

  // Width boundary either side of 30 us, and no clear while not latched
  task automatic t_clear(input logic latched, input int width, input int exp);
    cfg.func = pcio_pkg::PCIO_FUNC_CLEAR;
    protection_latched = latched;
    cyc(20);
    clr_cnt = 0;
    i_ext.pulse(width);
    cyc(20);
    `CHK(clr_cnt, exp)
  endtask : t_clear

  task automatic t_emit(input logic release_first, input int exp);
    cfg.func = pcio_pkg::PCIO_FUNC_CLEAR;
    load_on = 1'b0;
    if (release_first) begin
      protection_latched = 1'b1;
      cyc(2);
    end
    protection_latched = 1'b0;
    cyc(2);
    i_ext.clear_stats();
    load_on = 1'b1;
    cyc(3100);
    `CHK(i_ext.falls, exp)
    if (exp == 1) `CHK(i_ext.last_low, 3000)
  endtask : t_emit

  initial begin
    num_errors = 0;
    samples_checked = 0;
    clr_cnt = 0;
    nrst = 1'b0;
    cfg = '0;
    protection_latched = 1'b0;
    load_on = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(pin_oe, 1'b0)
    `CHK(pin_out, 1'b1)
    `CHK(protection_clear, 1'b0)
    `CHK(input_level, 1'b1)
    nrst = 1'b1;
    t_output();
    t_pwm();
    t_input();
    t_clear(1'b1, 3100, 1);
    t_clear(1'b1, 2990, 0);
    t_clear(1'b0, 3100, 0);
    cfg.invert = 1'b1;
    t_clear(1'b1, 3100, 1);
    cfg.invert = 1'b0;
    i_ext.release_pin();
    t_emit(1'b1, 1);
    t_emit(1'b0, 0);
    end_sim();
  end

  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule : testbench
